// >>> src/sensor_control_and_output_ports.sv
//
// Behaviour
// (R1) reset: mode pins, idle set, rest cleared
// (R2) mode bits read pins, writes ignored
// (R3) idle bit low while converting
// (R4) usb mode: finger event to endpoint two
// (R5) cpu/spi: finger event to interrupt path
// (R6) finger detect works while disabled
// (R7) step off: addresses stay after read
// (R8) step on: read advances column, converts
// (R9) column wrap advances row
// (R10) clock select bit ignored in usb mode
// (R11) enable low halts clock and converter
// (R12) enable high runs clock and converter
// (R13) second register resets to zero
// (R14) pin one rate field, zero is static
// (R15) pin one codes one to four divide
// (R16) pin zero rate field, zero is static
// (R17) pin zero codes one to four divide
// (R18) static level bit one drives pin one
// (R19) static level bit zero drives pin zero
// (R20) result read starts next conversion; code does so only with step enable on
// (R21) square waves from one binary prescaler
// (R22) reserved codes fall back to static level
`timescale 1ns/1ps
module sensor_control_and_output_ports #(
  parameter int convert_cycles = 6
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // register access
  input wire sensor_ctrl_pkg::bus_req_t bus_req,
  output logic [7:0] rdata,
  output logic rdata_valid,
  // converter result read strobe (same clock)
  input wire logic result_read,
  // pins from outside
  input wire logic [1:0] mode_pins,
  input wire logic finger_present,
  // pixel address handling
  input wire logic addr_load,
  input wire sensor_ctrl_pkg::pixel_addr_t addr_load_value,
  output sensor_ctrl_pkg::pixel_addr_t pixel_addr,
  // converter and clocking
  output logic converter_start,
  output logic converter_on,
  output logic logic_clock_run,
  output logic use_crystal,
  // finger detect routing
  output logic finger_event_usb,
  output logic finger_event_interrupt_output_pin,
  // general purpose outputs
  output logic out_zero_pin,
  output logic out_one_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strap_pending;
    logic [1:0] mode_latched;
    logic [4:0] scan_low;
    logic [7:0] port_ctrl;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [7:0] busy_count;
    logic start;
    logic finger_prev;
    logic finger_usb;
    logic finger_interrupt_output_pin;
    logic out_zero;
    logic out_one;
    sensor_ctrl_pkg::pixel_addr_t addr;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  // kept apart from the state record so that record has a single driver
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] mode_sync;
  logic finger_sync;
  logic [sensor_ctrl_pkg::prescaler_width-1:0] pre_count;
  logic running;
  logic is_usb;
  logic [1:0] wave;

  initial begin
    if (convert_cycles < 1 || convert_cycles > 255)
      $error("convert_cycles out of range");
  end

  // reset is released through two flops; assert is asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // pin synchronisers and prescaler
  // ----------------------------------------------------------------
  sync_two_ff #(.width(3)) pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({mode_pins, finger_present}),
    .q({mode_sync, finger_sync})
  );

  toggle_prescaler #(.width(sensor_ctrl_pkg::prescaler_width)) pre (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(running),
    .count(pre_count)
  );

  assign running = st.scan_low[sensor_ctrl_pkg::global_enable_bit];
  assign is_usb = st.mode_latched == sensor_ctrl_pkg::mode_usb;

  // stage picked per code: code 1 divides by 2^24, so it toggles on
  // stage 23; code 4 on stage 20
  function automatic logic rate_wave(input logic [2:0] code,
                                     input logic level,
                                     input logic [23:0] cnt);
    logic r;
    r = level; // see (R14) (R16) (R22)
    if (code != sensor_ctrl_pkg::rate_static &&
        code <= sensor_ctrl_pkg::rate_last_valid) begin
      r = cnt[5'(sensor_ctrl_pkg::rate_top_stage) - 5'(code) + 5'h01];
    end
    return r;
  endfunction : rate_wave

  assign wave[1] = rate_wave(
      st.port_ctrl[sensor_ctrl_pkg::out_one_rate_hi:
                   sensor_ctrl_pkg::out_one_rate_lo],
      st.port_ctrl[sensor_ctrl_pkg::out_one_level_bit],
      pre_count); // see (R15) (R18)
  assign wave[0] = rate_wave(
      st.port_ctrl[sensor_ctrl_pkg::out_zero_rate_hi:
                   sensor_ctrl_pkg::out_zero_rate_lo],
      st.port_ctrl[sensor_ctrl_pkg::out_zero_level_bit],
      pre_count); // see (R17) (R19)

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic step;
    logic idle;
    step = 1'b0;
    idle = 1'b0;
    next_st = st;
    next_st.rdata_valid = 1'b0;
    next_st.start = 1'b0;
    next_st.finger_usb = 1'b0;
    next_st.finger_interrupt_output_pin = 1'b0;
    if (ce) begin
      idle = st.busy_count == 8'h00;
      // mode pins caught once after reset release, then tracked
      next_st.strap_pending = 1'b0;
      next_st.mode_latched = mode_sync; // see (R1) (R2)
      // register reads; read-only fields come from live state
      if (bus_req.rd) begin
        next_st.rdata_valid = 1'b1;
        if (bus_req.addr ==
            sensor_ctrl_pkg::power_clock_scan_control_addr) begin
          next_st.rdata = {st.mode_latched, idle, st.scan_low}; // see (R2) (R3)
        end else if (bus_req.addr ==
                     sensor_ctrl_pkg::output_port_control_addr) begin
          next_st.rdata = st.port_ctrl;
        end else begin
          next_st.rdata = 8'h00;
        end
      end
      // writes: bits four and above of the first register are dropped
      if (bus_req.wr) begin
        if (bus_req.addr ==
            sensor_ctrl_pkg::power_clock_scan_control_addr) begin
          next_st.scan_low = bus_req.wdata[4:0]; // see (R2) (R3)
          next_st.scan_low[4] = 1'b0;
        end else if (bus_req.addr ==
                     sensor_ctrl_pkg::output_port_control_addr) begin
          next_st.port_ctrl = bus_req.wdata;
        end
      end
      // converter busy counter only runs while enabled
      if (!running) begin
        next_st.busy_count = 8'h00; // see (R11)
      end else if (!idle) begin
        next_st.busy_count = st.busy_count - 8'h01; // see (R12)
      end
      // result read kicks the next conversion when stepping
      if (result_read && running &&
          st.scan_low[sensor_ctrl_pkg::pixel_address_step_enable_bit]) begin
        step = 1'b1; // see (R7) (R8) (R20)
        next_st.start = 1'b1;
        next_st.busy_count = 8'(convert_cycles);
      end
      if (addr_load) begin
        next_st.addr = addr_load_value;
      end else if (step) begin
        if (st.addr.col == sensor_ctrl_pkg::last_column) begin
          next_st.addr.col = 8'h00; // see (R9)
          if (st.addr.row == sensor_ctrl_pkg::last_row) begin
            next_st.addr.row = 9'h000;
          end else begin
            next_st.addr.row = st.addr.row + 9'h001;
          end
        end else begin
          next_st.addr.col = st.addr.col + 8'h01; // see (R8)
        end
      end
      // finger detect edge, routed by mode, independent of enable
      next_st.finger_prev = finger_sync;
      if (finger_sync && !st.finger_prev &&
          st.scan_low[sensor_ctrl_pkg::finger_detect_enable_bit]) begin
        next_st.finger_usb = is_usb; // see (R4) (R6)
        next_st.finger_interrupt_output_pin = !is_usb; // see (R5) (R6)
      end
      // registered pin drivers
      next_st.out_zero = wave[0];
      next_st.out_one = wave[1];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.strap_pending <= 1'b1;
      st.mode_latched <= 2'h0;
      st.scan_low <= sensor_ctrl_pkg::scan_low_reset; // see (R1)
      st.port_ctrl <= sensor_ctrl_pkg::output_port_control_reset; // see (R13)
      st.rdata <= 8'h00;
      st.rdata_valid <= 1'b0;
      st.busy_count <= 8'h00;
      st.start <= 1'b0;
      st.finger_prev <= 1'b0;
      st.finger_usb <= 1'b0;
      st.finger_interrupt_output_pin <= 1'b0;
      st.out_zero <= 1'b0;
      st.out_one <= 1'b0;
      st.addr <= '0;
    end else begin
      st.strap_pending <= next_st.strap_pending;
      st.mode_latched <= next_st.mode_latched;
      st.scan_low <= next_st.scan_low;
      st.port_ctrl <= next_st.port_ctrl;
      st.rdata <= next_st.rdata;
      st.rdata_valid <= next_st.rdata_valid;
      st.busy_count <= next_st.busy_count;
      st.start <= next_st.start;
      st.finger_prev <= next_st.finger_prev;
      st.finger_usb <= next_st.finger_usb;
      st.finger_interrupt_output_pin <= next_st.finger_interrupt_output_pin;
      st.out_zero <= next_st.out_zero;
      st.out_one <= next_st.out_one;
      st.addr <= next_st.addr;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = st.rdata;
  assign rdata_valid = st.rdata_valid;
  assign pixel_addr = st.addr;
  assign converter_start = st.start;
  assign converter_on = running; // see (R11) (R12)
  assign logic_clock_run = running;
  // usb mode never selects the crystal side, select ignored
  assign use_crystal = !is_usb &&
      st.scan_low[sensor_ctrl_pkg::clock_source_select_bit]; // see (R10)
  assign finger_event_usb = st.finger_usb;
  assign finger_event_interrupt_output_pin = st.finger_interrupt_output_pin;
  assign out_zero_pin = st.out_zero;
  assign out_one_pin = st.out_one;

endmodule : sensor_control_and_output_ports

// >>> shared/sensor_ctrl_pkg.sv
package sensor_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] power_clock_scan_control_addr = 8'h09;
  localparam logic [7:0] output_port_control_addr = 8'h0A;
  localparam logic [7:0] output_port_control_reset = 8'h00;
  localparam logic [4:0] scan_low_reset = 5'h00;

  // ----------------------------------------------------------------
  // field positions, first control register
  // ----------------------------------------------------------------
  localparam int mode_hi_bit = 7;
  localparam int mode_lo_bit = 6;
  localparam int idle_bit = 5;
  localparam int finger_detect_enable_bit = 3;
  localparam int pixel_address_step_enable_bit = 2;
  localparam int clock_source_select_bit = 1;
  localparam int global_enable_bit = 0;

  // ----------------------------------------------------------------
  // field positions, second control register
  // ----------------------------------------------------------------
  localparam int out_one_rate_hi = 7;
  localparam int out_one_rate_lo = 5;
  localparam int out_zero_rate_hi = 4;
  localparam int out_zero_rate_lo = 2;
  localparam int out_one_level_bit = 1;
  localparam int out_zero_level_bit = 0;

  // ----------------------------------------------------------------
  // toggle rates and interface modes
  // ----------------------------------------------------------------
  localparam logic [2:0] rate_static = 3'h0;
  localparam logic [2:0] rate_last_valid = 3'h4;
  localparam int prescaler_width = 24;
  localparam int rate_top_stage = 23;
  localparam logic [1:0] mode_usb = 2'h2;
  localparam int column_width = 8;
  localparam int row_width = 9;
  localparam logic [8:0] last_row = 9'h12B;
  localparam logic [7:0] last_column = 8'hFF;

  // register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // pixel address pair
  typedef struct packed {
    logic [8:0] row;
    logic [7:0] col;
  } pixel_addr_t;

endpackage : sensor_ctrl_pkg

// >>> src/sync_two_ff.sv
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int width = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // level
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  typedef struct packed {
    logic [width-1:0] first;
    logic [width-1:0] second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  initial begin
    if (width < 1) $error("sync width must be positive");
  end

  // first stage feeds only the second stage
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.first = d;
      next_st.second = st.first;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.second;
endmodule : sync_two_ff

// >>> src/toggle_prescaler.sv
`timescale 1ns/1ps
module toggle_prescaler #(
  parameter int width = sensor_ctrl_pkg::prescaler_width
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // runs only while the logic clock is enabled
  input wire logic run,
  output logic [width-1:0] count
);
  typedef struct packed {
    logic [width-1:0] count;
  } pre_state_t;

  pre_state_t st;
  pre_state_t next_st;

  initial begin
    if (width < 2) $error("prescaler too narrow");
  end

  // binary count while run is high, each stage halves the rate
  always_comb begin
    next_st = st;
    if (ce && run) begin
      next_st.count = st.count + width'(1); // see (R21)
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
endmodule : toggle_prescaler

// >>> testbench/ctrl_properties.sv
`timescale 1ns/1ps
module ctrl_properties #(
  parameter int convert_cycles = 6
) (
  // clock, reset, host side
  input wire logic clk,
  input wire logic nrst,
  input wire sensor_ctrl_pkg::bus_req_t bus_req,
  input wire logic rdata_valid,
  input wire logic result_read,
  input wire logic addr_load,
  input wire sensor_ctrl_pkg::pixel_addr_t pixel_addr,
  // pins and converter
  input wire logic [1:0] mode_pins,
  input wire logic finger_present,
  input wire logic converter_start,
  input wire logic converter_on,
  input wire logic logic_clock_run,
  input wire logic use_crystal,
  input wire logic finger_event_usb,
  input wire logic finger_event_interrupt_output_pin
);
  localparam logic [1:0] usb = sensor_ctrl_pkg::mode_usb;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------
  // access, scanning, routing
  // ----------------------------
  a_read_answer: assert property (bus_req.rd |=> rdata_valid)
    else $error("read unanswered");
  a_start_cause: assert property (
    converter_start |-> $past(result_read) && converter_on)
    else $error("stray conversion");
  a_col_step: assert property (
    converter_start && $past(pixel_addr.col) != 8'hFF |->
    pixel_addr.col == $past(pixel_addr.col) + 8'h01
    && pixel_addr.row == $past(pixel_addr.row))
    else $error("column step wrong");
  a_row_step: assert property (
    converter_start && $past(pixel_addr.col) == 8'hFF |->
    pixel_addr.col == 8'h00 && pixel_addr.row ==
    ($past(pixel_addr.row) == sensor_ctrl_pkg::last_row ? 9'h000
    : $past(pixel_addr.row) + 9'h001))
    else $error("row step wrong");
  // a load or a result read are the only causes of an address change
  a_addr_hold: assert property (
    !$past(result_read) && !$past(addr_load) |-> $stable(pixel_addr))
    else $error("address moved");
  a_power_tie: assert property (converter_on == logic_clock_run)
    else $error("clock and converter split");
  // the mode pins pass a synchroniser, so allow the old mode a while
  a_xtal_usb: assert property (
    use_crystal |-> mode_pins != usb || $past(mode_pins, 5) != usb)
    else $error("crystal chosen in usb mode");
  a_usb_route: assert property (
    finger_event_usb |-> mode_pins == usb && $past(finger_present, 3))
    else $error("usb event wrong");
  a_interrupt_output_pin_route: assert property (
    finger_event_interrupt_output_pin |-> mode_pins != usb && $past(finger_present, 3))
    else $error("interrupt_output_pin event wrong");
  c_wrap: cover property (converter_start && $past(pixel_addr.col) == 8'hFF);
  c_usb: cover property (finger_event_usb);
  c_interrupt_output_pin: cover property (finger_event_interrupt_output_pin);
endmodule : ctrl_properties

bind sensor_control_and_output_ports ctrl_properties #(
  .convert_cycles(convert_cycles)) props (.clk(clk), .nrst(nrst),
  .bus_req(bus_req), .rdata_valid(rdata_valid), .result_read(result_read),
  .addr_load(addr_load), .pixel_addr(pixel_addr), .mode_pins(mode_pins),
  .finger_present(finger_present), .converter_start(converter_start),
  .converter_on(converter_on), .logic_clock_run(logic_clock_run),
  .use_crystal(use_crystal), .finger_event_usb(finger_event_usb),
  .finger_event_interrupt_output_pin(finger_event_interrupt_output_pin));

// >>> testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // register bus
  output sensor_ctrl_pkg::bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid
);
  // released lines show inverted values so stale data cannot pass
  initial bus_req = '{rd: 1'b0, wr: 1'b0, addr: 8'h55, wdata: 8'hAA};
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~a};
    @(negedge clk);
    bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: a};
    // bounded wait for the answer
    for (int i = 0; i < 3 && rdata_valid !== 1'b1; i++) @(negedge clk);
    d = (rdata_valid === 1'b1) ? rdata : 8'hXX;
  endtask : rd
endmodule : host_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------
  // signals and instances
  // ----------------------------
  localparam logic [7:0] scan = sensor_ctrl_pkg::power_clock_scan_control_addr;
  localparam logic [7:0] outs = sensor_ctrl_pkg::output_port_control_addr;
  localparam logic [1:0] usb = sensor_ctrl_pkg::mode_usb;
  logic clk, nrst, ce, result_read, finger_present, addr_load, rdata_valid;
  logic converter_start, converter_on, logic_clock_run, use_crystal;
  logic finger_event_usb, finger_event_interrupt_output_pin, out_zero_pin, out_one_pin;
  logic [1:0] mode_pins;
  logic [7:0] rdata, got, data, n_usb, n_interrupt_output_pin;
  sensor_ctrl_pkg::bus_req_t bus_req;
  sensor_ctrl_pkg::pixel_addr_t addr_load_value, pixel_addr, v;
  int error_cnt, n_checks;
  sensor_control_and_output_ports #(.convert_cycles(6)) dut (
    .clk(clk), .nrst(nrst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
    .rdata_valid(rdata_valid), .result_read(result_read),
    .mode_pins(mode_pins), .finger_present(finger_present),
    .addr_load(addr_load), .addr_load_value(addr_load_value),
    .pixel_addr(pixel_addr), .converter_start(converter_start),
    .converter_on(converter_on), .logic_clock_run(logic_clock_run),
    .use_crystal(use_crystal), .finger_event_usb(finger_event_usb),
    .finger_event_interrupt_output_pin(finger_event_interrupt_output_pin), .out_zero_pin(out_zero_pin),
    .out_one_pin(out_one_pin));
  host_model host (.clk(clk), .bus_req(bus_req), .rdata(rdata),
    .rdata_valid(rdata_valid));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------
  // checking helpers
  // ----------------------------
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t byte %h expected %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic chk_addr(input sensor_ctrl_pkg::pixel_addr_t g,
                          input sensor_ctrl_pkg::pixel_addr_t e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t address %h expected %h", $time, g, e);
    end
  endtask : chk_addr
  function automatic sensor_ctrl_pkg::pixel_addr_t step_addr(
      input sensor_ctrl_pkg::pixel_addr_t a);
    step_addr = a;
    step_addr.col = a.col + 8'h01;
    if (a.col == sensor_ctrl_pkg::last_column) begin
      step_addr.row = (a.row == sensor_ctrl_pkg::last_row) ? 9'h000
                      : a.row + 9'h001;
    end
  endfunction : step_addr
  // prescaler taps stay low in so short a run, so codes 1..4 read low
  function automatic logic pin_exp(input logic [2:0] c, input logic lvl);
    pin_exp = (c == 3'h0 || c > 3'h4) ? lvl : 1'b0;
  endfunction : pin_exp
  task automatic pulse_read(input sensor_ctrl_pkg::pixel_addr_t a);
    @(negedge clk);
    addr_load = 1'b1;
    addr_load_value = a;
    @(negedge clk);
    addr_load = 1'b0;
    addr_load_value = ~a;
    result_read = 1'b1;
    @(negedge clk);
    result_read = 1'b0;
  endtask : pulse_read
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    result_read = 1'b0;
    finger_present = 1'b0;
    addr_load = 1'b0;
    addr_load_value = '0;
    mode_pins = 2'h1;
    error_cnt = 0;
    n_checks = 0;
    data = 8'($urandom(32'hD73A));
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    // reset release, pin synchroniser and mode capture take five edges
    repeat (8) @(negedge clk);
    host.rd(scan, got);
    chk_reg(got, 8'h60);
    host.rd(outs, got);
    chk_reg(got, 8'h00);
    chk_bit(logic_clock_run, 1'b0);
    host.wr(scan, 8'hFF);
    host.rd(scan, got);
    chk_reg(got, 8'h6F);
    chk_bit(converter_on, 1'b1);
    chk_bit(use_crystal, 1'b1);
    mode_pins = usb;
    repeat (6) @(negedge clk);
    chk_bit(use_crystal, 1'b0);
    // scanning: wrap corners first, then random addresses
    for (int i = 0; i < 20; i++) begin
      v.col = (i < 2) ? 8'hFF : 8'($urandom);
      v.row = (i == 0) ? sensor_ctrl_pkg::last_row
              : 9'($urandom_range(int'(sensor_ctrl_pkg::last_row)));
      pulse_read(v);
      chk_bit(converter_start, 1'b1);
      chk_addr(pixel_addr, step_addr(v));
      host.rd(scan, got);
      chk_reg(got, 8'h8F);
      repeat (8) @(negedge clk);
      host.rd(scan, got);
      chk_reg(got, 8'hAF);
    end
    host.wr(scan, 8'h01);
    pulse_read(v);
    chk_bit(converter_start, 1'b0);
    chk_addr(pixel_addr, v);
    // finger detection in every mode, detect on and off, chip disabled
    for (int m = 0; m < 8; m++) begin
      mode_pins = m[1:0];
      host.wr(scan, {4'h0, m[2], 3'h0});
      repeat (6) @(negedge clk);
      n_usb = 8'h00;
      n_interrupt_output_pin = 8'h00;
      finger_present = 1'b1;
      repeat (18) begin
        @(negedge clk);
        if (converter_on !== 1'b0) finger_present = 1'b0;
        n_usb = n_usb + {7'h00, finger_event_usb};
        n_interrupt_output_pin = n_interrupt_output_pin + {7'h00, finger_event_interrupt_output_pin};
      end
      finger_present = 1'b0;
      chk_reg(n_usb, {7'h00, m[2] && m[1:0] == usb});
      chk_reg(n_interrupt_output_pin, {7'h00, m[2] && m[1:0] != usb});
    end
    // output port: every rate code in both fields, then random values
    for (int i = 0; i < 24; i++) begin
      data = 8'($urandom);
      if (i < 8) data[7:2] = {3'(i), 3'(7 - i)};
      host.wr(outs, data);
      host.rd(outs, got);
      chk_reg(got, data);
      chk_bit(out_one_pin, pin_exp(data[7:5], data[1]));
      chk_bit(out_zero_pin, pin_exp(data[4:2], data[0]));
    end
    host.wr(8'h0B, 8'hFF);
    host.rd(8'h0B, got);
    chk_reg(got, 8'h00);
    host.rd(outs, got);
    chk_reg(got, data);
    // clock enable low freezes the registers, so the write is lost
    ce = 1'b0;
    host.wr(outs, ~data);
    @(negedge clk);
    ce = 1'b1;
    host.rd(outs, got);
    chk_reg(got, data);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    host.rd(scan, got);
    chk_reg(got, 8'hE0);
    host.rd(outs, got);
    chk_reg(got, 8'h00);
    complete_run();
  end
endmodule : testbench
